/* File: common/spimp_pkg.sv */
package spimp_pkg;

    //------------------------------------------------------------
    // widths and ranges
    //------------------------------------------------------------
    localparam int SPIMP_CS_NUM = 4;
    localparam int SPIMP_CHAR_MAX = 32;
    localparam int SPIMP_FRAME_MAX = 4096;
    localparam int SPIMP_DIV_W = 16;
    localparam int SPIMP_LEN_W = 5;
    localparam int SPIMP_FCNT_W = 12;
    localparam int SPIMP_DLY_W = 2;

    //------------------------------------------------------------
    // reset values
    //------------------------------------------------------------
    localparam logic [31:0] SPIMP_DATA_RST = 32'h0000_0000;
    localparam logic [15:0] SPIMP_DIV_RST = 16'h0000;
    localparam logic [4:0] SPIMP_LEN_RST = 5'h00;
    localparam logic [11:0] SPIMP_FCNT_RST = 12'h000;
    localparam logic [1:0] SPIMP_DLY_RST = 2'h0;

    //------------------------------------------------------------
    // configuration carrier
    //------------------------------------------------------------
    typedef struct packed {
        logic [15:0] clk_div;
        logic [4:0] char_len_m1;
        logic [11:0] frame_len_m1;
        logic [1:0] cs_sel;
        logic [1:0] cs_delay;
        logic clock_idle_polarity;
        logic clock_phase_select;
        logic cs_active_high;
        logic char_irq_en;
        logic loopback;
    } spimp_cfg_t;

    typedef enum logic [4:0] {
        SPIMP_IDLE = 5'h01,
        SPIMP_DELAY = 5'h02,
        SPIMP_LEAD = 5'h04,
        SPIMP_TRAIL = 5'h08,
        SPIMP_DONE = 5'h10
    } spimp_state_t;

endpackage

/* File: rtl/spimp_master.sv */
`timescale 1ns/1ps
`default_nettype none

module spimp_master
    import spimp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire spimp_cfg_t cfg_in,
    input wire logic start_in,
    input wire logic [31:0] tx_data_in,
    output logic tx_ready_out,
    output logic [31:0] rx_data_out,
    output logic rx_valid_out,
    output logic char_irq_out,
    output logic busy_out,
    output logic spi_clk_out,
    output logic spi_tx_out,
    input wire logic spi_rx_in,
    output logic [3:0] slave_select_n_out
);

    //------------------------------------------------------------
    // receive pin synchroniser
    //------------------------------------------------------------
    logic rx_meta;
    logic rx_sync;
    logic next_rx_meta;
    logic next_rx_sync;

    always_comb begin
        next_rx_meta = spi_rx_in;
        next_rx_sync = rx_meta;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else if (clk_en_in) begin
            rx_meta <= next_rx_meta;
            rx_sync <= next_rx_sync;
        end
    end

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------
    spimp_state_t state;
    spimp_state_t next_state;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [11:0] char_cnt;
    logic [11:0] next_char_cnt;
    logic [1:0] dly_cnt;
    logic [1:0] next_dly_cnt;
    logic dly_half;
    logic next_dly_half;
    logic [31:0] tx_shift;
    logic [31:0] next_tx_shift;
    logic [31:0] rx_shift;
    logic [31:0] next_rx_shift;
    logic [31:0] rx_data;
    logic [31:0] next_rx_data;
    logic rx_valid;
    logic next_rx_valid;
    logic char_irq;
    logic next_char_irq;
    logic sclk_act;
    logic next_sclk_act;
    logic tx_bit;
    logic next_tx_bit;
    logic cs_on;
    logic next_cs_on;
    logic need_data;
    logic next_need_data;
    logic tick;
    logic rx_bit;
    logic last_bit;

    assign tick = (div_cnt == SPIMP_DIV_RST);
    assign rx_bit = cfg_in.loopback ? tx_bit : rx_sync;
    assign last_bit = (bit_cnt == cfg_in.char_len_m1);

    always_comb begin
        next_state = state;
        next_div_cnt = tick ? cfg_in.clk_div : div_cnt - 16'h0001;
        next_bit_cnt = bit_cnt;
        next_char_cnt = char_cnt;
        next_dly_cnt = dly_cnt;
        next_dly_half = dly_half;
        next_tx_shift = tx_shift;
        next_rx_shift = rx_shift;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_char_irq = 1'b0;
        next_sclk_act = sclk_act;
        next_tx_bit = tx_bit;
        next_cs_on = cs_on;
        next_need_data = need_data;
        case (state)
            SPIMP_IDLE: begin
                next_div_cnt = cfg_in.clk_div;
                if (start_in) begin
                    next_cs_on = 1'b1;
                    next_tx_shift = tx_data_in;
                    next_bit_cnt = SPIMP_LEN_RST;
                    next_char_cnt = SPIMP_FCNT_RST;
                    next_dly_cnt = cfg_in.cs_delay;
                    next_dly_half = 1'b0;
                    next_state = SPIMP_DELAY;
                end
            end
            SPIMP_DELAY: begin
                if (tick) begin
                    if (dly_cnt == SPIMP_DLY_RST) begin
                        next_tx_bit = tx_shift[cfg_in.char_len_m1];
                        next_state = SPIMP_LEAD;
                    end else begin
                        // one count is a whole bit time: two ticks
                        next_dly_half = ~dly_half;
                        if (dly_half) begin
                            next_dly_cnt = dly_cnt - 2'h1;
                        end
                    end
                end
            end
            SPIMP_LEAD: begin
                if (tick && !need_data) begin
                    next_sclk_act = 1'b1;
                    next_rx_shift = {rx_shift[30:0], rx_bit};
                    next_state = SPIMP_TRAIL;
                end else if (need_data) begin
                    next_div_cnt = cfg_in.clk_div;
                    if (start_in) begin
                        next_tx_shift = tx_data_in;
                        next_tx_bit = tx_data_in[cfg_in.char_len_m1];
                        next_need_data = 1'b0;
                    end
                end
            end
            SPIMP_TRAIL: begin
                if (tick) begin
                    next_sclk_act = 1'b0;
                    if (last_bit) begin
                        next_rx_data = rx_shift;
                        next_rx_valid = 1'b1;
                        next_char_irq = cfg_in.char_irq_en;
                        next_bit_cnt = SPIMP_LEN_RST;
                        if (char_cnt == cfg_in.frame_len_m1) begin
                            next_state = SPIMP_DONE;
                        end else begin
                            next_char_cnt = char_cnt + 12'h001;
                            next_need_data = 1'b1;
                            next_state = SPIMP_LEAD;
                        end
                    end else begin
                        next_bit_cnt = bit_cnt + 5'h01;
                        next_tx_bit = tx_shift[cfg_in.char_len_m1 - bit_cnt
                            - 5'h01];
                        next_state = SPIMP_LEAD;
                    end
                end
            end
            SPIMP_DONE: begin
                if (tick) begin
                    next_cs_on = 1'b0;
                    next_state = SPIMP_IDLE;
                end
            end
            default: begin
                next_state = SPIMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state <= SPIMP_IDLE;
            div_cnt <= SPIMP_DIV_RST;
            bit_cnt <= SPIMP_LEN_RST;
            char_cnt <= SPIMP_FCNT_RST;
            dly_cnt <= SPIMP_DLY_RST;
            dly_half <= 1'b0;
            tx_shift <= SPIMP_DATA_RST;
            rx_shift <= SPIMP_DATA_RST;
            rx_data <= SPIMP_DATA_RST;
            rx_valid <= 1'b0;
            char_irq <= 1'b0;
            sclk_act <= 1'b0;
            tx_bit <= 1'b0;
            cs_on <= 1'b0;
            need_data <= 1'b0;
        end else if (clk_en_in) begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            bit_cnt <= next_bit_cnt;
            char_cnt <= next_char_cnt;
            dly_cnt <= next_dly_cnt;
            dly_half <= next_dly_half;
            tx_shift <= next_tx_shift;
            rx_shift <= next_rx_shift;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            char_irq <= next_char_irq;
            sclk_act <= next_sclk_act;
            tx_bit <= next_tx_bit;
            cs_on <= next_cs_on;
            need_data <= next_need_data;
        end
    end

    //------------------------------------------------------------
    // pins
    //------------------------------------------------------------
    // phase 1 launches on leading edge: shift clock by half bit
    logic sclk_lvl;
    assign sclk_lvl = cfg_in.clock_phase_select
        ? (state == SPIMP_LEAD && !need_data)
        : sclk_act;

    always_comb begin
        spi_clk_out = cfg_in.clock_idle_polarity ^ sclk_lvl;
        spi_tx_out = tx_bit;
        for (int i = 0; i < SPIMP_CS_NUM; i++) begin
            slave_select_n_out[i] = (cs_on && cfg_in.cs_sel == i[1:0])
                ? cfg_in.cs_active_high : ~cfg_in.cs_active_high;
        end
    end

    // no dma request; software paces through tx_ready_out
    assign tx_ready_out = (state == SPIMP_IDLE) ||
        (state == SPIMP_LEAD && need_data);
    assign rx_data_out = rx_data;
    assign rx_valid_out = rx_valid;
    assign char_irq_out = char_irq;
    assign busy_out = (state != SPIMP_IDLE);

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    // low bits that belong to the current character
    logic [31:0] char_mask;
    assign char_mask = 32'hffff_ffff >> (5'h1f - cfg_in.char_len_m1);

    sequence s_frame_start;
        state == SPIMP_IDLE && start_in && clk_en_in;
    endsequence

    sequence s_select_up;
        cs_on && state == SPIMP_DELAY;
    endsequence

    sequence s_frame_end;
        state == SPIMP_DONE && tick && clk_en_in;
    endsequence

    sequence s_select_down;
        !cs_on && state == SPIMP_IDLE;
    endsequence

    AST_IRQ_GATED: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        char_irq_out |-> $past(cfg_in.char_irq_en))
        else $error("char irq while disabled");
    AST_IRQ_WITH_RX: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        char_irq_out |-> rx_valid_out)
        else $error("irq without character");
    AST_ONE_CS: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        busy_out |->
        $onehot(slave_select_n_out ^ {4{~cfg_in.cs_active_high}}))
        else $error("not exactly one select in frame");
    AST_CS_IDLE: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        state == SPIMP_IDLE && $past(state) == SPIMP_IDLE
        |-> slave_select_n_out == {4{~cfg_in.cs_active_high}})
        else $error("select held while idle");
    AST_CLK_IDLE: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        state == SPIMP_IDLE |-> spi_clk_out == cfg_in.clock_idle_polarity)
        else $error("clock not at idle level");
    AST_DELAY_CLK: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        state == SPIMP_DELAY |-> spi_clk_out == cfg_in.clock_idle_polarity)
        else $error("clock moved during select delay");
    AST_LOOP: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        cfg_in.loopback && rx_valid_out
        |-> ((rx_data_out ^ tx_shift) & char_mask) == 32'h0000_0000)
        else $error("loopback data differs");
    AST_BITCNT: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        busy_out |-> bit_cnt <= cfg_in.char_len_m1)
        else $error("bit count past length");
    AST_FRAMECNT: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        busy_out |-> char_cnt <= cfg_in.frame_len_m1)
        else $error("char count past frame");
    AST_START_SEL: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_frame_start |=> s_select_up)
        else $error("frame start without select");
    AST_END_SEL: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_frame_end |=> s_select_down)
        else $error("select kept after frame");

endmodule

`default_nettype wire

/* File: sim/spimp_master_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spimp_master_bench
    import spimp_pkg::*;
;
    localparam logic [31:0] REPLY = 32'hc3a5_5a3c;
    localparam logic [31:0] TXD = 32'h9e37_61b4;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic start = 1'b0;
    logic [31:0] tx_data = 32'h0;
    spimp_cfg_t cfg;
    logic tx_ready, rx_valid, char_irq, busy, spi_clk, spi_tx, spi_rx, sel;
    logic [31:0] rx_data, got;
    logic [3:0] ss;
    logic pclk = 1'b0;
    logic psel = 1'b0;
    logic clk_en = 1'b1;
    int failures = 0;
    int check_count = 0;
    int cyc = 0, edges = 0, t_sel = 0, t_e1 = 0, t_e3 = 0, irqs = 0;
    always #2 clk_in = ~clk_in;
    assign sel = ss[cfg.cs_sel] ~^ cfg.cs_active_high;
    spimp_master DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .clk_en_in(clk_en), .cfg_in(cfg), .start_in(start),
        .tx_data_in(tx_data), .tx_ready_out(tx_ready),
        .rx_data_out(rx_data), .rx_valid_out(rx_valid),
        .char_irq_out(char_irq), .busy_out(busy), .spi_clk_out(spi_clk),
        .spi_tx_out(spi_tx), .spi_rx_in(spi_rx), .slave_select_n_out(ss));
    spimp_slave_model slave (.clk_in(clk_in), .sclk_in(spi_clk),
        .mosi_in(spi_tx), .sel_in(sel), .cpol_in(cfg.clock_idle_polarity),
        .cpha_in(cfg.clock_phase_select),
        .len_in({1'b0, cfg.char_len_m1} + 6'h01), .reply_in(REPLY),
        .miso_out(spi_rx), .got_out(got));
    // -------------------------
    // wire monitor
    // -------------------------
    always @(negedge clk_in) begin
        cyc++;
        if (sel && !psel) begin
            t_sel = cyc;
            edges = 0;
        end
        if (sel && spi_clk != pclk) begin
            edges++;
            if (edges == 1) t_e1 = cyc;
            if (edges == 3) t_e3 = cyc;
        end
        if (char_irq === 1'b1) irqs++;
        pclk = spi_clk;
        psel = sel;
    end
    // -------------------------
    // shared tasks
    // -------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic frame(input int nch);
        logic [31:0] m;
        int n;
        m = 32'hffff_ffff >> (5'h1f - cfg.char_len_m1);
        cfg.frame_len_m1 = 12'(nch - 1);
        irqs = 0;
        for (int i = 0; i < nch; i++) begin
            n = 0;
            while (tx_ready !== 1'b1 && n < 5000) begin
                @(negedge clk_in);
                n++;
            end
            start = 1'b1;
            tx_data = TXD;
            @(negedge clk_in);
            start = 1'b0;
            check("ready after start", tx_ready, 1'b0);
            n = 0;
            while (rx_valid !== 1'b1 && n < 5000) begin
                @(negedge clk_in);
                n++;
            end
            check("rx_valid", rx_valid, 1'b1);
            check("rx_data", rx_data & m, (cfg.loopback ? TXD : REPLY) & m);
            check("slave got", got & m, TXD & m);
            if (i < nch - 1) begin
                check("selects", ss, 4'(cfg.cs_active_high ? 4'h1 << cfg.cs_sel
                    : ~(4'h1 << cfg.cs_sel)));
            end
        end
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk_in);
            n++;
        end
        @(negedge clk_in);
        check("idle selects", ss, {4{~cfg.cs_active_high}});
        check("idle clock", spi_clk, cfg.clock_idle_polarity);
        check("edges", edges, 2 * nch * (cfg.char_len_m1 + 1));
        check("irqs", irqs, cfg.char_irq_en ? nch : 0);
        if (cfg.char_len_m1 != 5'h00) begin
            check("bit period", t_e3 - t_e1, 2 * (cfg.clk_div + 1));
        end
    endtask
    // -------------------------
    // scenarios
    // -------------------------
    task automatic t_modes();
        for (int k = 0; k < 4; k++) begin
            cfg.clock_idle_polarity = k[1];
            cfg.clock_phase_select = k[0];
            cfg.cs_sel = k[1:0];
            cfg.cs_active_high = k[0];
            frame(2);
        end
        cfg = '{clk_div: 16'h0003, char_len_m1: 5'h07, char_irq_en: 1'b1,
            default: '0};
        $display("modes done");
    endtask
    task automatic t_lengths();
        cfg.char_len_m1 = 5'h00;
        frame(3);
        cfg.char_len_m1 = 5'h1f;
        frame(2);
        cfg.char_len_m1 = 5'h07;
        $display("lengths done");
    endtask
    task automatic t_quiet_loop();
        cfg.char_irq_en = 1'b0;
        cfg.loopback = 1'b1;
        cfg.clk_div = 16'h0005;
        frame(3);
        cfg = '{clk_div: 16'h0003, char_len_m1: 5'h07, char_irq_en: 1'b1,
            default: '0};
        $display("quiet loopback done");
    endtask
    task automatic t_delay();
        int d0;
        frame(1);
        d0 = t_e1 - t_sel;
        cfg.cs_delay = 2'h3;
        frame(1);
        // three bit times, each two half periods
        check("select delay", t_e1 - t_sel - d0, 6 * (cfg.clk_div + 1));
        $display("delay done");
    endtask
    task automatic t_freeze();
        logic held_clk;
        int held_edges;
        cfg.cs_delay = 2'h0;
        fork
            frame(1);
            begin
                while (busy !== 1'b1) @(negedge clk_in);
                repeat (28) @(negedge clk_in);
                clk_en = 1'b0;
                @(negedge clk_in);
                held_clk = spi_clk;
                held_edges = edges;
                repeat (20) @(negedge clk_in);
                check("frozen clock", spi_clk, held_clk);
                check("frozen edges", edges, held_edges);
                clk_en = 1'b1;
            end
        join
        $display("freeze done");
    endtask
    initial begin
        cfg = '{clk_div: 16'h0003, char_len_m1: 5'h07, char_irq_en: 1'b1,
            default: '0};
        repeat (6) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        check("reset selects", ss, 4'hf);
        check("reset clock", spi_clk, 1'b0);
        check("reset busy", busy, 1'b0);
        $display("reset done");
        t_modes();
        t_lengths();
        t_quiet_loop();
        t_delay();
        t_freeze();
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: sim/spimp_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// far side slave
// ----------------
module spimp_slave_model (
    input wire logic clk_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic sel_in,
    input wire logic cpol_in,
    input wire logic cpha_in,
    input wire logic [5:0] len_in,
    input wire logic [31:0] reply_in,
    output logic miso_out,
    output logic [31:0] got_out
);
    logic cap;
    int idx = 0;
    initial miso_out = 1'b0;
    initial got_out = 32'h0;
    // high on the capture half of each bit
    assign cap = sel_in && ((sclk_in != cpol_in) ^ cpha_in);
    always @(posedge sel_in) begin
        idx = cpha_in ? 0 : len_in - 1;
        miso_out = reply_in[idx];
    end
    always @(posedge cap) begin
        got_out = {got_out[30:0], mosi_in};
    end
    always @(negedge cap) begin
        if (sel_in) begin
            idx = (idx == 0) ? len_in - 1 : idx - 1;
            miso_out = reply_in[idx];
        end
    end
    // released line keeps changing
    always @(negedge clk_in) begin
        if (!sel_in) begin
            miso_out <= ~miso_out;
        end
    end
endmodule
`default_nettype wire
